// *** hw/msum_consts.svh ***
// constants of the memory-system usage monitor: offsets, fields, timing
//======================================================================
// Summary of operation
// - config change raises not-ready until settled
// - not-ready clears itself within settle time
// - each instance keeps its own not-ready
// - software may write not-ready either way
// - plain read-write not-ready is also allowed
// - capture copies count with not-ready flag
// - capture is immediate, no handshake
// - fire write makes local capture if present
// - non-secure fire hits non-secure source-7 monitors
// - secure fire hits secure, or all spaces
// - clear after capture zeroes the count
// - wrap flag sticks until software writes 0
// - halt on wrap freezes, else wraps
// - wrap interrupt only when enabled
// - instance select steers filter and control access
// - filter holds partition and group, top zero
// - match enables restrict partition or group
// - kind code reads bandwidth monitor constant
// - extra match criteria read zero here
// - source select; unimplemented sources never capture
// - no snapshot support makes source zero
// - enable bit gates counting; capture runs regardless
`ifndef MSUM_CONSTS_SVH
`define MSUM_CONSTS_SVH

//======================================================================
// register byte offsets
`define MSUM_OFS_SELECT      8'h00
`define MSUM_OFS_FILTER      8'h04
`define MSUM_OFS_CONTROL     8'h08
`define MSUM_OFS_COUNT       8'h0c
`define MSUM_OFS_CAPTURE     8'h10
`define MSUM_OFS_TRIG_NS     8'h14
`define MSUM_OFS_TRIG_S      8'h18
`define MSUM_OFS_INFO        8'h1c

//======================================================================
// field positions
`define MSUM_CTL_ENABLE      31
`define MSUM_CTL_SRC_HI      30
`define MSUM_CTL_SRC_LO      28
`define MSUM_CTL_CLR_CAPT    27
`define MSUM_CTL_WRAP_SEEN   26
`define MSUM_CTL_WRAP_IRQ    25
`define MSUM_CTL_HALT_WRAP   24
`define MSUM_CTL_BY_GROUP    17
`define MSUM_CTL_BY_PART     16
`define MSUM_FLT_PART_HI     15
`define MSUM_FLT_GRP_LO      16
`define MSUM_FLT_GRP_HI      23
`define MSUM_CNT_NOT_READY_FLAG        31
`define MSUM_TRIG_FIRE       0
`define MSUM_TRIG_ALL        1

//======================================================================
// build options and reset values
`define MSUM_NUM_INST        4
`define MSUM_KIND_BW         8'h42
`define MSUM_SRC_LOCAL       3'h7
`define MSUM_EXT_PRESENT     7'h7f
`define MSUM_SECURE_MASK     4'hc
`define MSUM_LOCAL_PRESENT   1'b1
`define MSUM_SNAPSHOT        1'b1
`define MSUM_RESET_WORD      32'h00000000

//======================================================================
// timing
`define MSUM_CLK_NS          50
`define MSUM_SETTLE_NS       2000
`define MSUM_SETTLE_CYC      (`MSUM_SETTLE_NS / `MSUM_CLK_NS)

`endif

// *** hw/msum_pkg.sv ***
// types shared by the memory-system usage monitor
package msum_pkg;
	typedef logic [1:0]  msum_sel_type;
	typedef logic [30:0] msum_cnt_type;
	typedef logic [23:0] msum_flt_type;
	typedef logic [7:0]  msum_settle_type;
endpackage

// *** hw/msum_monitor.sv ***
// bandwidth usage monitor bank with capture, overflow and ahb-lite regs
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "msum_consts.svh"

module msum_monitor (
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic      [31:0] HRDATA,
	input  wire logic        TXN_VALID,
	input  wire logic [15:0] TXN_PARTITION,
	input  wire logic [7:0]  TXN_GROUP,
	input  wire logic [7:0]  TXN_BYTES,
	input  wire logic [6:0]  CAPT_EXT,
	output logic             WRAP_IRQ
);

	localparam int N = `MSUM_NUM_INST;

	// option masks held as vectors so each instance (SECURE_SET) or source (EXT_PRESENT) picks its own bit
	localparam logic [3:0] SECURE_SET  = `MSUM_SECURE_MASK;
	localparam logic [6:0] EXT_PRESENT = `MSUM_EXT_PRESENT;

	//==================================================================
	// bus address phase capture
	logic                  dp_valid;
	logic                  dp_write;
	logic [7:0]            dp_addr;
	logic                  rd_wait;
	wire                   addr_take;
	wire                   rd_take;

	assign addr_take = HSEL & HTRANS[1] & HREADY;
	assign rd_take   = addr_take & ~HWRITE;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (HREADY) begin
			dp_valid <= addr_take;
			dp_write <= HWRITE;
			dp_addr  <= HADDR;
		end
	end

	// one wait state on reads so a write just before is visible
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			rd_wait <= 1'b0;
		end else begin
			rd_wait <= rd_take;
		end
	end

	assign HREADYOUT = ~rd_wait;
	assign HRESP     = 1'b0;

	//==================================================================
	// write strobes
	wire        wr_en;
	wire        wr_sel;
	wire        wr_flt;
	wire        wr_ctl;
	wire        wr_cnt;
	wire        wr_cap;
	wire        wr_trig_ns;
	wire        wr_trig_s;

	assign wr_en      = dp_valid & dp_write;
	assign wr_sel     = wr_en & (dp_addr == `MSUM_OFS_SELECT);
	assign wr_flt     = wr_en & (dp_addr == `MSUM_OFS_FILTER);
	assign wr_ctl     = wr_en & (dp_addr == `MSUM_OFS_CONTROL);
	assign wr_cnt     = wr_en & (dp_addr == `MSUM_OFS_COUNT);
	assign wr_cap     = wr_en & (dp_addr == `MSUM_OFS_CAPTURE);
	assign wr_trig_ns = wr_en & (dp_addr == `MSUM_OFS_TRIG_NS);
	assign wr_trig_s  = wr_en & (dp_addr == `MSUM_OFS_TRIG_S);

	//==================================================================
	// instance select
	msum_pkg::msum_sel_type inst_sel;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			inst_sel <= '0;
		end else if (wr_sel) begin
			inst_sel <= HWDATA[1:0];
		end
	end

	//==================================================================
	// local capture events
	wire        fire_ns;
	wire        fire_s;
	wire        fire_all;
	wire [7:0]  ext_live;

	assign fire_ns  = `MSUM_LOCAL_PRESENT & wr_trig_ns
		& HWDATA[`MSUM_TRIG_FIRE];
	assign fire_s   = `MSUM_LOCAL_PRESENT & wr_trig_s
		& HWDATA[`MSUM_TRIG_FIRE];
	assign fire_all = fire_s & HWDATA[`MSUM_TRIG_ALL];
	// bit 7 stays low: source 7 is the local trigger, never a pin
	assign ext_live = {1'b0, CAPT_EXT & EXT_PRESENT};

	//==================================================================
	// per-instance state
	msum_pkg::msum_flt_type    filt      [N];
	msum_pkg::msum_cnt_type    count     [N];
	msum_pkg::msum_settle_type settle    [N];
	logic [31:0]               capt      [N];
	logic                      not_ready_flag      [N];
	logic                      en        [N];
	logic [2:0]                src       [N];
	logic                      clr_capt  [N];
	logic                      wrap_seen [N];
	logic                      irq_en    [N];
	logic                      halt      [N];
	logic                      by_grp    [N];
	logic                      by_part   [N];
	logic [N-1:0]              irq_hit;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_inst
			wire        me;
			wire        cfg_wr;
			wire        secure;
			wire        ext_ev;
			wire        loc_ev;
			wire        cap_ev;
			wire        match;
			wire        frozen;
			wire        incr;
			wire [31:0] sum;
			wire        ovf;

			assign me     = (inst_sel == 2'(gi));
			assign cfg_wr = me & (wr_flt | wr_ctl);
			assign secure = SECURE_SET[gi];

			// unimplemented external inputs are masked off
			assign ext_ev = ext_live[src[gi]];
			assign loc_ev = (src[gi] == `MSUM_SRC_LOCAL)
				& ((secure & fire_s)
				| (~secure & (fire_ns | fire_all)));
			assign cap_ev = `MSUM_SNAPSHOT & (ext_ev | loc_ev);

			assign match = (~by_part[gi]
				| (filt[gi][`MSUM_FLT_PART_HI:0] == TXN_PARTITION))
				& (~by_grp[gi]
				| (filt[gi][`MSUM_FLT_GRP_HI:`MSUM_FLT_GRP_LO]
				== TXN_GROUP));
			assign frozen = halt[gi] & wrap_seen[gi];
			assign incr   = en[gi] & TXN_VALID & match
				& ~frozen;
			assign sum    = {1'b0, count[gi]} + {24'h000000, TXN_BYTES};
			assign ovf    = incr & sum[31];
			assign irq_hit[gi] = ovf & irq_en[gi];

			// filter: top byte is not stored, so it reads zero
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					filt[gi] <= '0;
				end else if (me & wr_flt) begin
					filt[gi] <= HWDATA[23:0];
				end
			end

			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					en[gi]       <= 1'b0;
					src[gi]      <= 3'h0;
					clr_capt[gi] <= 1'b0;
					irq_en[gi]   <= 1'b0;
					halt[gi]     <= 1'b0;
					by_grp[gi]   <= 1'b0;
					by_part[gi]  <= 1'b0;
				end else if (me & wr_ctl) begin
					en[gi]       <= HWDATA[`MSUM_CTL_ENABLE];
					src[gi]      <= `MSUM_SNAPSHOT
						? HWDATA[`MSUM_CTL_SRC_HI:`MSUM_CTL_SRC_LO]
						: 3'h0;
					clr_capt[gi] <= HWDATA[`MSUM_CTL_CLR_CAPT];
					irq_en[gi]   <= HWDATA[`MSUM_CTL_WRAP_IRQ];
					halt[gi]     <= HWDATA[`MSUM_CTL_HALT_WRAP];
					by_grp[gi]   <= HWDATA[`MSUM_CTL_BY_GROUP];
					by_part[gi]  <= HWDATA[`MSUM_CTL_BY_PART];
				end
			end

			// overflow sets the flag even against a clearing write
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					wrap_seen[gi] <= 1'b0;
				end else if (ovf) begin
					wrap_seen[gi] <= 1'b1;
				end else if (me & wr_ctl) begin
					wrap_seen[gi] <= HWDATA[`MSUM_CTL_WRAP_SEEN];
				end
			end

			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					count[gi] <= '0;
				end else if (me & wr_cnt) begin
					count[gi] <= HWDATA[30:0];
				end else if (cap_ev & clr_capt[gi]) begin
					count[gi] <= '0;
				end else if (incr) begin
					count[gi] <= sum[30:0];
				end
			end

			// a config change outranks capture and software writes
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					not_ready_flag[gi]   <= 1'b0;
					settle[gi] <= '0;
				end else if (cfg_wr) begin
					not_ready_flag[gi]   <= 1'b1;
					settle[gi] <= 8'(`MSUM_SETTLE_CYC);
				end else if (me & wr_cnt) begin
					not_ready_flag[gi]   <= HWDATA[`MSUM_CNT_NOT_READY_FLAG];
					settle[gi] <= '0;
				end else if (cap_ev) begin
					not_ready_flag[gi]   <= 1'b0;
					settle[gi] <= '0;
				end else if (settle[gi] != 8'h00) begin
					settle[gi] <= settle[gi] - 8'h01;
					if (settle[gi] == 8'h01) begin
						not_ready_flag[gi] <= 1'b0;
					end
				end
			end

			// capture takes the value held before this edge
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					capt[gi] <= `MSUM_RESET_WORD;
				end else if (cap_ev) begin
					capt[gi] <= {not_ready_flag[gi], count[gi]};
				end else if (me & wr_cap) begin
					capt[gi] <= HWDATA;
				end
			end
		end
	endgenerate

	//==================================================================
	// interrupt pulse
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			WRAP_IRQ <= 1'b0;
		end else begin
			WRAP_IRQ <= |irq_hit;
		end
	end

	//==================================================================
	// read data
	wire [31:0] rd_flt;
	wire [31:0] rd_ctl;
	wire [31:0] rd_cnt;
	wire [31:0] rd_info;
	wire [31:0] rd_mux;

	assign rd_flt  = {8'h00, filt[inst_sel]};
	assign rd_ctl  = {en[inst_sel], src[inst_sel], clr_capt[inst_sel],
		wrap_seen[inst_sel], irq_en[inst_sel], halt[inst_sel],
		4'h0, 2'b00, by_grp[inst_sel], by_part[inst_sel],
		8'h00, `MSUM_KIND_BW};
	assign rd_cnt  = {not_ready_flag[inst_sel], count[inst_sel]};
	assign rd_info = {13'h0000, `MSUM_SNAPSHOT, `MSUM_LOCAL_PRESENT,
		17'(N)};
	assign rd_mux  =
		(dp_addr == `MSUM_OFS_SELECT)  ? {30'h00000000, inst_sel} :
		(dp_addr == `MSUM_OFS_FILTER)  ? rd_flt :
		(dp_addr == `MSUM_OFS_CONTROL) ? rd_ctl :
		(dp_addr == `MSUM_OFS_COUNT)   ? rd_cnt :
		(dp_addr == `MSUM_OFS_CAPTURE) ? capt[inst_sel] :
		(dp_addr == `MSUM_OFS_INFO)    ? rd_info :
		32'h00000000;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			HRDATA <= 32'h00000000;
		end else if (rd_wait) begin
			HRDATA <= rd_mux;
		end
	end

endmodule // msum_monitor

// *** verification/msum_monitor_chk.sv ***
// assertions on the usage monitor's register bus and interrupt ports
`timescale 1ns/1ps
module msum_monitor_chk (
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        HSEL,
	input wire logic [7:0]  HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic        HREADYOUT,
	input wire logic [31:0] HRDATA,
	input wire logic        WRAP_IRQ
);
	//==========================================================
	// bus decode
	wire take = HSEL & HTRANS[1] & HREADY;
	wire rd   = take & !HWRITE;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	//==========================================================
	// properties
	rd_wait_a: assert property (rd |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	wr_nowait_a: assert property (take && HWRITE |=> HREADYOUT)
		else $error("write got a wait state");
	// read data must not drift between reads
	rdata_hold_a: assert property ($changed(HRDATA) |-> $past(rd, 2))
		else $error("read data changed without a read");
	flt_top_a: assert property (rd && HADDR == 8'h04 |->
		##2 (HRDATA[31:24] == 8'h00))
		else $error("filter top byte not zero");
	kind_code_a: assert property (rd && HADDR == 8'h08 |->
		##2 (HRDATA[7:0] == 8'h42))
		else $error("kind code wrong");
	// match enables at 17:16 may be either value; bits 23:18 and 15:8 read zero
	ctl_raz_a: assert property (rd && HADDR == 8'h08 |->
		##2 (HRDATA[23:18] == 6'h00 && HRDATA[15:8] == 8'h00))
		else $error("reserved control bits not zero");
	info_caps_a: assert property (rd && HADDR == 8'h1c |->
		##2 (HRDATA[18:17] == 2'h3))
		else $error("capability bits wrong");
	irq_pulse_a: assert property (WRAP_IRQ |=> !WRAP_IRQ)
		else $error("wrap interrupt longer than one cycle");
endmodule // msum_monitor_chk

bind msum_monitor msum_monitor_chk u_chk (.MCLK, .RST_N, .HSEL, .HADDR,
	.HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRDATA, .WRAP_IRQ);

// *** verification/msum_txn_src.sv ***
// transfer flow and capture event sources facing the monitor
`timescale 1ns/1ps
module msum_txn_src (
	input  wire logic        mclk,
	output logic             txn_valid,
	output logic      [15:0] txn_partition,
	output logic      [7:0]  txn_group,
	output logic      [7:0]  txn_bytes,
	output logic      [6:0]  capt_ext
);
	//==========================================================
	// drivers
	initial begin
		txn_valid = 1'b0;
		txn_partition = 16'h0;
		txn_group = 8'h0;
		txn_bytes = 8'h0;
		capt_ext = 7'h0;
	end
	// leading edge keeps back-to-back calls from driving twice at once
	task automatic send(input int n, input logic [15:0] p,
		input logic [7:0] g, input logic [7:0] b);
		@(posedge mclk);
		repeat (n) begin
			txn_valid <= 1'b1;
			txn_partition <= p;
			txn_group <= g;
			txn_bytes <= b;
			@(posedge mclk);
		end
		// idle attributes are junk, never the last transfer's
		txn_valid <= 1'b0;
		txn_partition <= ~p;
		txn_group <= ~g;
		txn_bytes <= ~b;
	endtask
	task automatic pulse(input int k);
		capt_ext <= 7'h01 << k;
		@(posedge mclk);
		capt_ext <= 7'h00;
	endtask
endmodule // msum_txn_src

// *** verification/testbench.sv ***
// self-checking bench of the usage monitor over ahb-lite
`timescale 1ns/1ps
`include "msum_consts.svh"
module testbench;
	logic        MCLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic        HREADYOUT, HRESP, WRAP_IRQ, TXN_VALID, rdy;
	logic [1:0]  HTRANS = 2'h0;
	logic [2:0]  HSIZE = 3'h2;
	logic [6:0]  CAPT_EXT;
	logic [7:0]  HADDR = 8'h0, TXN_GROUP, TXN_BYTES;
	logic [15:0] TXN_PARTITION;
	logic [31:0] HWDATA = 32'h0, HRDATA, rdq;
	int          bad_count = 0, compares = 0, cyc = 0, irq_cnt = 0;
	int          irq_base = 0;

	msum_monitor dut (.MCLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
		.HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .TXN_VALID,
		.TXN_PARTITION, .TXN_GROUP, .TXN_BYTES, .CAPT_EXT, .WRAP_IRQ);
	msum_txn_src src (.mclk(MCLK), .txn_valid(TXN_VALID),
		.txn_partition(TXN_PARTITION), .txn_group(TXN_GROUP),
		.txn_bytes(TXN_BYTES), .capt_ext(CAPT_EXT));

	initial forever #25 MCLK = ~MCLK;
	// sampling at the falling edge gives the value the rising edge sees
	always @(negedge MCLK) begin
		rdy <= HREADYOUT;
		rdq <= HRDATA;
		if (WRAP_IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			end_of_test;
		end
	end
	//==========================================================
	// bus tasks
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= a;
		do @(posedge MCLK); while (rdy !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge MCLK); while (rdy !== 1'b1);
		q = rdq;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q & m, e);
	endtask
	task automatic cfg(input logic [31:0] ctl, cnt);
		w(8'h08, ctl);
		w(8'h0c, cnt);
	endtask
	task end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	//==========================================================
	// tests
	initial begin
		repeat (20) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		rc(8'h08, '1, 32'h00000042);
		chk("hresp", {31'h0, HRESP}, 32'h0);
		rc(8'h1c, 32'h0007ffff, 32'h00060004);
		rc(8'h20, '1, 32'h0);
		w(8'h04, '1);
		rc(8'h04, '1, 32'h00ffffff);
		w(8'h08, 32'hfbffffff);
		rc(8'h08, '1, 32'hfb030042);
		repeat (`MSUM_SETTLE_CYC + 1) @(posedge MCLK);
		rc(8'h0c, 32'h80000000, 32'h0);
		w(8'h00, 32'h1);
		w(8'h04, 32'h00091234);
		rc(8'h0c, 32'h80000000, 32'h80000000);
		w(8'h00, 32'h0);
		rc(8'h0c, 32'h80000000, 32'h0);
		rc(8'h04, '1, 32'h00ffffff);
		w(8'h04, 32'h00090005);
		cfg(32'h80010000, 32'h0);
		src.send(3, 16'h5, 8'h9, 8'ha);
		src.send(2, 16'h6, 8'h9, 8'ha);
		rc(8'h0c, '1, 32'h1e);
		cfg(32'h80030000, 32'h0);
		src.send(2, 16'h5, 8'h8, 8'ha);
		src.send(1, 16'h5, 8'h9, 8'h4);
		rc(8'h0c, '1, 32'h4);
		cfg(32'h00030000, 32'h80000000);
		src.send(2, 16'h5, 8'h9, 8'h4);
		rc(8'h0c, '1, 32'h80000000);
		cfg(32'hb8000000, 32'h80000005);
		src.pulse(2);
		rc(8'h10, '1, 32'h0);
		src.pulse(3);
		rc(8'h10, '1, 32'h80000005);
		rc(8'h0c, '1, 32'h0);
		cfg(32'h90000000, 32'h9);
		src.pulse(1);
		rc(8'h10, '1, 32'h9);
		rc(8'h0c, '1, 32'h9);
		cfg(32'hf0000000, 32'h3);
		w(8'h18, 32'h1);
		rc(8'h10, '1, 32'h9);
		w(8'h14, 32'h1);
		rc(8'h10, '1, 32'h3);
		w(8'h00, 32'h2);
		cfg(32'hf0000000, 32'h6);
		w(8'h14, 32'h1);
		rc(8'h10, '1, 32'h0);
		w(8'h18, 32'h1);
		rc(8'h10, '1, 32'h6);
		w(8'h00, 32'h0);
		w(8'h0c, 32'h4);
		w(8'h18, 32'h3);
		rc(8'h10, '1, 32'h4);
		cfg(32'h82000000, 32'h7ffffff0);
		irq_base = irq_cnt;
		src.send(1, 16'h0, 8'h0, 8'h20);
		rc(8'h0c, 32'h7fffffff, 32'h10);
		rc(8'h08, 32'h04000000, 32'h04000000);
		chk("wrap irq", 32'(irq_cnt - irq_base), 32'h1);
		cfg(32'h81000000, 32'h7ffffff0);
		irq_base = irq_cnt;
		src.send(3, 16'h0, 8'h0, 8'h20);
		rc(8'h0c, 32'h7fffffff, 32'h10);
		chk("wrap irq", 32'(irq_cnt - irq_base), 32'h0);
		rc(8'h08, 32'h04000000, 32'h04000000);
		w(8'h08, 32'h81000000);
		rc(8'h08, 32'h04000000, 32'h0);
		end_of_test;
	end
endmodule // testbench
